/* File: hw/sfc_buf2.sv */
`timescale 1ns/1ns
module sfc_buf2 #(
  parameter int W = 8
) (
  input  wire logic   clk_in,
  input  wire logic   nrst_in,
  sfc_stream_if.snk   in_s,
  sfc_stream_if.src   out_s
);
  logic [W-1:0] mem_q [2];
  logic         wp_q;
  logic         rp_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  generate
    if (W < 1) begin : g_chk
      $error("sfc_buf2 width must be positive");
    end
  endgenerate

  // honest full and empty from the occupancy count
  assign in_s.ready  = (cnt_q != 2'h2);
  assign out_s.valid = (cnt_q != 2'h0);
  assign out_s.data  = mem_q[rp_q];
  assign push = in_s.valid && in_s.ready;
  assign pop  = out_s.valid && out_s.ready;

  // storage written only on accepted pushes
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else if (push) begin
      mem_q[wp_q] <= in_s.data;
    end
  end

  // pointers and count
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wp_q <= ~wp_q;
      if (pop) rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  AST_BUF_NO_OVERRUN: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (cnt_q == 2'h2 && !pop) |=> cnt_q == 2'h2)
    else $error("full buffer lost its contents");
endmodule // sfc_buf2

/* File: hw/sfc_pkg.sv */
package sfc_pkg;
  // transmit shifter states
  typedef enum logic [1:0] {
    SFC_TX_IDLE  = 2'h0,
    SFC_TX_SHIFT = 2'h1
  } sfc_tx_state_type;

  // receive states, gray along idle-start-data-stop
  typedef enum logic [1:0] {
    SFC_RX_IDLE  = 2'h0,
    SFC_RX_START = 2'h1,
    SFC_RX_DATA  = 2'h3,
    SFC_RX_STOP  = 2'h2
  } sfc_rx_state_type;
endpackage

/* File: hw/sfc_prescale.sv */
`timescale 1ns/1ns
`include "sfc_regs.svh"
module sfc_prescale #(
  parameter int PRE_W = 6
) (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic [1:0] sel_in,
  output logic            tick_out
);
  logic [PRE_W-1:0] cnt_q;
  logic [PRE_W-1:0] mask;

  generate
    if (PRE_W < 6) begin : g_chk
      $error("sfc_prescale needs at least six counter bits");
    end
  endgenerate

  // mask picks the divide ratio; tick whenever all masked bits are set
  always_comb begin
    case (sel_in)
      2'h0:    mask = PRE_W'(`SFC_PRE_MASK1);
      2'h1:    mask = PRE_W'(`SFC_PRE_MASK4);
      2'h2:    mask = PRE_W'(`SFC_PRE_MASK16);
      2'h3:    mask = PRE_W'(`SFC_PRE_MASK64);
      default: mask = PRE_W'(`SFC_PRE_MASK1);
    endcase
  end

  // free-running count; a ratio change takes effect within one period
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign tick_out = ((cnt_q & mask) == mask);

  AST_PRE_DIV64: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (tick_out && sel_in == 2'h3 && $stable(sel_in)) |=> (!tick_out || sel_in != 2'h3) [*8])
    else $error("divide by 64 ticked too early");
endmodule // sfc_prescale

/* File: hw/sfc_regs.svh */
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH

// register indices on the 3-bit address port
`define SFC_ADDR_MODE      3'h0
`define SFC_ADDR_HOLD      3'h1
`define SFC_ADDR_CARD      3'h2
`define SFC_ADDR_CTRL      3'h3
`define SFC_ADDR_DIV       3'h4
`define SFC_ADDR_RXDATA    3'h5

// reset values
`define SFC_MODE_RST       8'h00
`define SFC_CARD_RST       8'h00
`define SFC_CTRL_RST       8'h00
`define SFC_DIV_RST        8'h0f
`define SFC_RD_ZERO        8'h00

// mode register fields
`define SFC_MODE_SYNC      7
`define SFC_MODE_CHR       6
`define SFC_MODE_PAR       5
`define SFC_MODE_ODD       4
`define SFC_MODE_STOP      3
`define SFC_MODE_MP        2
`define SFC_MODE_BCP_HI    3
`define SFC_MODE_BCP_LO    2
`define SFC_MODE_CKS_HI    1
`define SFC_MODE_CKS_LO    0

// card mode register and control/status fields
`define SFC_CARD_IFACE     0
`define SFC_CTRL_MPB       0
`define SFC_STAT_TXRDY     1
`define SFC_STAT_BUSY      2
`define SFC_STAT_RXFULL    3
`define SFC_STAT_PERR      4
`define SFC_STAT_FERR      5
`define SFC_STAT_RXMPB     6

// prescale masks for /1, /4, /16, /64
`define SFC_PRE_MASK1      6'h00
`define SFC_PRE_MASK4      6'h03
`define SFC_PRE_MASK16     6'h0f
`define SFC_PRE_MASK64     6'h3f

// basic clocks per bit in card mode
`define SFC_S_32           9'h020
`define SFC_S_64           9'h040
`define SFC_S_372          9'h174
`define SFC_S_256          9'h100

// frame lengths in bits
`define SFC_START_BITS     4'h1
`define SFC_DATA_BITS      4'h8
`define SFC_DATA_BITS_7    4'h7
`define SFC_STOP_ONE       4'h1
`define SFC_STOP_TWO       4'h2
`define SFC_RX_SH_W        4'h9

`endif

/* File: hw/sfc_stream_if.sv */
`timescale 1ns/1ns
interface sfc_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: hw/sfc_top.sv */
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`include "sfc_regs.svh"
// Summary of operation
// - holding word moves to shifter, then shifts out
// - shifter has no register address
// - mode bit 7 picks asynchronous or synchronous
// - async bit 6 picks eight or seven bits
// - seven bits: LSB first, bit 7 dropped
// - synchronous mode always sends eight bits
// - parity enable adds and checks parity
// - multiprocessor format never uses parity
// - bit 4 picks even or odd parity
// - bit 3 picks one or two stops
// - receiver checks first stop bit only
// - bit 2 enables multiprocessor format
// - prescale field divides clock 1/4/16/64
// - card mode reinterprets bits 7,6,3,2
// - card bits 3:2 pick 32/64/372/256 clocks
module sfc_top
  import sfc_pkg::*;
#(
  parameter int PRE_W = 6
) (
  input  wire logic       CLK_SYS_IN,
  input  wire logic       NRST_IN,
  input  wire logic [2:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  input  wire logic       WR_IN,
  input  wire logic       RD_IN,
  output logic      [7:0] RDATA_OUT,
  input  wire logic       RXD_IN,
  output logic            TXD_OUT,
  output logic            SCK_OUT,
  output logic            SCK_OE_OUT,
  output logic            TX_READY_OUT
);
  logic [7:0]       mode_q;
  logic [7:0]       card_q;
  logic [7:0]       ctrl_q;
  logic [7:0]       div_q;
  logic [7:0]       rdata_q;
  logic             card;
  logic             sync;
  logic             seven;
  logic             mp_on;
  logic             par_on;
  logic             odd;
  logic             two_stop;
  logic [8:0]       card_s;
  logic [8:0]       lim;
  logic             pre_tick;
  sfc_tx_state_type tx_st_q;
  logic [11:0]      sh_q;
  logic [3:0]       left_q;
  logic [8:0]       tx_cnt_q;
  logic             sck_q;
  logic             tx_bit_end;
  logic             load;
  logic [11:0]      frame;
  logic [3:0]       flen;
  logic [3:0]       idx;
  logic             tx_par;
  logic [7:0]       tx_data;
  logic             rx_s1_q;
  logic             rx_s2_q;
  sfc_rx_state_type rx_st_q;
  logic [8:0]       rx_cnt_q;
  logic [8:0]       rx_sh_q;
  logic [3:0]       rx_left_q;
  logic             rx_sample;
  logic [8:0]       rx_target;
  logic [3:0]       rx_nb;
  logic [8:0]       rx_al;
  logic [7:0]       rx_word;
  logic             rx_extra;
  logic             rx_done;
  logic             rx_perr;
  logic [7:0]       rx_data_q;
  logic             rx_full_q;
  logic             perr_q;
  logic             ferr_q;
  logic             rx_mpb_q;
  logic             rd_rx;

  sfc_stream_if #(.W(8)) hold_if ();
  sfc_stream_if #(.W(8)) shift_if ();

  // mode field decode; card mode reuses bits 7,6,3,2 for other purposes
  assign card     = card_q[`SFC_CARD_IFACE];
  assign sync     = !card && mode_q[`SFC_MODE_SYNC];
  assign seven    = !card && !sync && mode_q[`SFC_MODE_CHR];
  assign mp_on    = !card && !sync && mode_q[`SFC_MODE_MP];
  assign par_on   = !sync && !mp_on && mode_q[`SFC_MODE_PAR];
  assign odd      = mode_q[`SFC_MODE_ODD];
  assign two_stop = card || (!sync && mode_q[`SFC_MODE_STOP]);

  // card bit period in basic clocks
  always_comb begin
    case ({mode_q[`SFC_MODE_BCP_HI], mode_q[`SFC_MODE_BCP_LO]})
      2'h0:    card_s = `SFC_S_32;
      2'h1:    card_s = `SFC_S_64;
      2'h2:    card_s = `SFC_S_372;
      2'h3:    card_s = `SFC_S_256;
      default: card_s = `SFC_S_32;
    endcase
  end

  // bit period in prescaled ticks, minus one
  assign lim = card ? (card_s - 9'h001) : {1'b0, div_q};

  sfc_prescale #(.PRE_W(PRE_W)) u_pre (
    .clk_in   (CLK_SYS_IN),
    .nrst_in  (NRST_IN),
    .sel_in   ({mode_q[`SFC_MODE_CKS_HI], mode_q[`SFC_MODE_CKS_LO]}),
    .tick_out (pre_tick)
  );

  // holding buffer: software writes push, the shifter pops
  assign hold_if.valid = WR_IN && (ADDR_IN == `SFC_ADDR_HOLD);
  assign hold_if.data  = WDATA_IN;
  assign TX_READY_OUT  = hold_if.ready;
  assign shift_if.ready = (tx_st_q == SFC_TX_IDLE);
  assign load = shift_if.valid && shift_if.ready;

  sfc_buf2 #(.W(8)) u_buf (
    .clk_in  (CLK_SYS_IN),
    .nrst_in (NRST_IN),
    .in_s    (hold_if.snk),
    .out_s   (shift_if.src)
  );

  // mode, card and control registers
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      mode_q <= `SFC_MODE_RST;
      card_q <= `SFC_CARD_RST;
      ctrl_q <= `SFC_CTRL_RST;
      div_q  <= `SFC_DIV_RST;
    end else if (WR_IN) begin
      case (ADDR_IN)
        `SFC_ADDR_MODE: mode_q <= WDATA_IN;
        `SFC_ADDR_CARD: card_q <= {7'h00, WDATA_IN[`SFC_CARD_IFACE]};
        `SFC_ADDR_CTRL: ctrl_q <= {7'h00, WDATA_IN[`SFC_CTRL_MPB]};
        `SFC_ADDR_DIV:  div_q  <= WDATA_IN;
        default: ;
      endcase
    end
  end

  // read mux; the shifter itself is not decoded at any address
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rdata_q <= `SFC_RD_ZERO;
    end else if (RD_IN) begin
      case (ADDR_IN)
        `SFC_ADDR_MODE:   rdata_q <= mode_q;
        `SFC_ADDR_HOLD:   rdata_q <= shift_if.data;
        `SFC_ADDR_CARD:   rdata_q <= card_q;
        `SFC_ADDR_CTRL:   rdata_q <= {1'b0, rx_mpb_q, ferr_q, perr_q, rx_full_q,
                                      (tx_st_q != SFC_TX_IDLE), hold_if.ready, ctrl_q[`SFC_CTRL_MPB]};
        `SFC_ADDR_DIV:    rdata_q <= div_q;
        `SFC_ADDR_RXDATA: rdata_q <= rx_data_q;
        default:          rdata_q <= `SFC_RD_ZERO;
      endcase
    end else begin
      rdata_q <= `SFC_RD_ZERO;
    end
  end
  assign RDATA_OUT = rdata_q;

  // frame image, LSB first, start at bit 0; stops come from the ones fill
  assign tx_data = shift_if.data;
  assign tx_par  = (seven ? ^tx_data[6:0] : ^tx_data) ^ odd;
  always_comb begin
    frame = 12'hfff;
    idx   = `SFC_START_BITS;
    flen  = `SFC_DATA_BITS;
    if (sync) begin
      frame[7:0] = tx_data;
    end else begin
      frame[0]   = 1'b0;
      frame[7:1] = tx_data[6:0];
      if (!seven) frame[8] = tx_data[7];
      idx = seven ? (`SFC_START_BITS + `SFC_DATA_BITS_7) : (`SFC_START_BITS + `SFC_DATA_BITS);
      if (par_on || mp_on) begin
        frame[idx] = mp_on ? ctrl_q[`SFC_CTRL_MPB] : tx_par;
        idx = idx + 4'h1;
      end
      flen = idx + (two_stop ? `SFC_STOP_TWO : `SFC_STOP_ONE);
    end
  end

  // bit timer restarts at each load; the first bit is full length only at prescale /1, as the prescaler runs free
  assign tx_bit_end = pre_tick && (tx_cnt_q == lim);
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tx_cnt_q <= 9'h000;
    end else if (load || tx_st_q == SFC_TX_IDLE) begin
      tx_cnt_q <= 9'h000;
    end else if (pre_tick) begin
      tx_cnt_q <= tx_bit_end ? 9'h000 : tx_cnt_q + 9'h001;
    end
  end

  // transmit shifter: loaded by hardware, shifted right with ones fill
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tx_st_q <= SFC_TX_IDLE;
      sh_q    <= 12'hfff;
      left_q  <= 4'h0;
    end else begin
      case (tx_st_q)
        SFC_TX_IDLE: begin
          if (load) begin
            sh_q    <= frame;
            left_q  <= flen;
            tx_st_q <= SFC_TX_SHIFT;
          end
        end
        SFC_TX_SHIFT: begin
          if (tx_bit_end) begin
            sh_q   <= {1'b1, sh_q[11:1]};
            left_q <= left_q - 4'h1;
            if (left_q == 4'h1) tx_st_q <= SFC_TX_IDLE;
          end
        end
        default: tx_st_q <= SFC_TX_IDLE;
      endcase
    end
  end
  assign TXD_OUT = sh_q[0];

  // sync clock from next-cycle state so it rises mid-bit, never on a data change; div must be nonzero
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      sck_q <= 1'b1;
    end else begin
      sck_q <= !(sync && (load || (tx_st_q == SFC_TX_SHIFT && !(tx_bit_end && left_q == 4'h1))))
               || (!load && !tx_bit_end && ((pre_tick ? tx_cnt_q + 9'h001 : tx_cnt_q) > (lim >> 1)));
    end
  end
  assign SCK_OUT    = sck_q;
  assign SCK_OE_OUT = sync;

  // two-stage synchroniser on the receive pin
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= RXD_IN;
      rx_s2_q <= rx_s1_q;
    end
  end

  // receive sampling: half a bit into start, then one full bit apart
  assign rx_target = (rx_st_q == SFC_RX_START) ? (lim >> 1) : lim;
  assign rx_sample = pre_tick && (rx_cnt_q == rx_target);
  assign rx_nb     = (seven ? `SFC_DATA_BITS_7 : `SFC_DATA_BITS) + {3'h0, (par_on || mp_on)};
  assign rx_al     = rx_sh_q >> (`SFC_RX_SH_W - rx_nb);
  assign rx_word   = seven ? {1'b0, rx_al[6:0]} : rx_al[7:0];
  assign rx_extra  = seven ? rx_al[7] : rx_al[8];
  assign rx_perr   = par_on && ((^rx_word ^ rx_extra) != odd);
  assign rx_done   = (rx_st_q == SFC_RX_STOP) && rx_sample;
  assign rd_rx     = RD_IN && (ADDR_IN == `SFC_ADDR_RXDATA);

  // receive state machine; synchronous mode receive is not served
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rx_st_q   <= SFC_RX_IDLE;
      rx_cnt_q  <= 9'h000;
      rx_sh_q   <= 9'h000;
      rx_left_q <= 4'h0;
    end else begin
      rx_cnt_q <= (rx_st_q == SFC_RX_IDLE || rx_sample) ? 9'h000 :
                  (pre_tick ? rx_cnt_q + 9'h001 : rx_cnt_q);
      case (rx_st_q)
        SFC_RX_IDLE: begin
          if (!rx_s2_q && !sync) rx_st_q <= SFC_RX_START;
        end
        SFC_RX_START: begin
          if (rx_sample) begin
            rx_st_q   <= rx_s2_q ? SFC_RX_IDLE : SFC_RX_DATA;
            rx_left_q <= rx_nb;
          end
        end
        SFC_RX_DATA: begin
          if (rx_sample) begin
            rx_sh_q   <= {rx_s2_q, rx_sh_q[8:1]};
            rx_left_q <= rx_left_q - 4'h1;
            if (rx_left_q == 4'h1) rx_st_q <= SFC_RX_STOP;
          end
        end
        SFC_RX_STOP: begin
          if (rx_sample) rx_st_q <= SFC_RX_IDLE;
        end
        default: rx_st_q <= SFC_RX_IDLE;
      endcase
    end
  end

  // receive results; a frame ending in the read cycle wins over the clear
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rx_data_q <= 8'h00;
      rx_full_q <= 1'b0;
      perr_q    <= 1'b0;
      ferr_q    <= 1'b0;
      rx_mpb_q  <= 1'b0;
    end else if (rx_done) begin
      rx_data_q <= rx_word;
      rx_full_q <= 1'b1;
      perr_q    <= rx_perr;
      ferr_q    <= !rx_s2_q;
      rx_mpb_q  <= mp_on && rx_extra;
    end else if (rd_rx) begin
      rx_full_q <= 1'b0;
      perr_q    <= 1'b0;
      ferr_q    <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!NRST_IN);

  AST_TX_IDLE_MARK: assert property (tx_st_q == SFC_TX_IDLE |-> TXD_OUT)
    else $error("line not idle high between frames");
  AST_TX_LOAD_START: assert property ((load && !sync) |=> (tx_st_q == SFC_TX_SHIFT && !TXD_OUT))
    else $error("start bit not driven after load");
  AST_TX_SEVEN_LEN: assert property ((load && seven && !par_on && !mp_on && !two_stop) |=> left_q == 4'h9)
    else $error("seven bit frame has wrong length");
  AST_TX_SYNC_LEN: assert property ((load && sync) |=> (left_q == 4'h8 && sh_q[11:8] == 4'hf))
    else $error("synchronous frame not eight bits");
  AST_TX_PARITY: assert property ((load && par_on && !seven && !card) |=>
    sh_q[9] == ($past(^shift_if.data) ^ $past(odd)))
    else $error("parity bit value wrong");
  AST_MP_NO_PAR: assert property (mp_on |-> !par_on)
    else $error("parity used with multiprocessor format");
  AST_TX_TWO_STOP: assert property ((load && two_stop && !card && !seven && !mp_on && !mode_q[`SFC_MODE_PAR]) |=>
    left_q == 4'hb)
    else $error("two stop frame has wrong length");
  AST_RX_FIRST_STOP: assert property ((rx_st_q == SFC_RX_STOP && rx_sample) |=> rx_st_q == SFC_RX_IDLE)
    else $error("receiver waited past first stop");
  AST_CARD_372: assert property ((card && mode_q[3:2] == 2'h2) |-> lim == 9'h173)
    else $error("card bit period not 372");
  AST_MODE_RESET: assert property ($rose(NRST_IN) |-> mode_q == `SFC_MODE_RST)
    else $error("mode register not cleared by reset");
  AST_SHIFT_HOLDS: assert property ((tx_st_q == SFC_TX_SHIFT && !tx_bit_end) |=> $stable(sh_q))
    else $error("shifter changed outside a bit edge");

  COV_SYNC_FRAME: cover property (load && sync);
  COV_CARD_FRAME: cover property (load && card && par_on);
  COV_RX_PERR: cover property (rx_done && rx_perr);
  COV_BUF_FULL: cover property (!hold_if.ready ##1 load);
endmodule // sfc_top

/* File: testbench/sfc_link_model.sv */
`timescale 1ns/1ns
// remote transceiver: reads frames off the wire and sends frames back
module sfc_link_model (
  input  wire logic clk_in,
  input  wire logic txd_in,
  input  wire logic sck_in,
  output logic      rxd_out
);
  // idle line is high until a frame is sent
  initial rxd_out = 1'b1;

  // one-clock bits; negedge sampling keeps clear of the design's updates
  task automatic grab(input int n, output logic [15:0] f);
    int c;
    c = 0;
    f = '1;
    while (txd_in !== 1'b0 && c < 300) begin
      @(negedge clk_in);
      c++;
    end
    for (int j = 0; j < n; j++) begin
      if (j > 0) @(negedge clk_in);
      f[j] = txd_in;
    end
  endtask

  // clocks from the last stop bit to the next start bit, 50 if none
  task automatic gap(output int g);
    g = 0;
    do begin
      @(negedge clk_in);
      g++;
    end while (txd_in !== 1'b0 && g < 50);
  endtask

  // length of data bit 0 of a 0x55 frame; start bit may be cut short
  task automatic bit_len(output int p);
    int c;
    c = 0;
    p = 0;
    while (txd_in !== 1'b0 && c < 3000) begin
      @(negedge clk_in);
      c++;
    end
    while (txd_in !== 1'b1 && c < 3000) begin
      @(negedge clk_in);
      c++;
    end
    while (txd_in === 1'b1 && p < 1000) begin
      @(negedge clk_in);
      p++;
    end
  endtask

  // clocked mode: one bit at each rising serial clock, lsb first
  task automatic sync_grab(output logic [7:0] d, output int r);
    logic p;
    p = sck_in;
    r = 0;
    d = '0;
    repeat (60) begin
      @(negedge clk_in);
      if (p === 1'b0 && sck_in === 1'b1) begin
        d = {txd_in, d[7:1]};
        r++;
      end
      p = sck_in;
    end
  endtask

  // sends n bits lsb first, p clocks each, then releases to idle high
  task automatic send(input logic [31:0] b, input int n, input int p);
    for (int j = 0; j < n; j++) begin
      rxd_out <= b[j];
      repeat (p) @(posedge clk_in);
    end
    rxd_out <= 1'b1;
  endtask
endmodule // sfc_link_model

/* File: testbench/tb_top.sv */
`timescale 1ns/1ns
`include "sfc_regs.svh"
module tb_top;
  logic       clk;
  logic       nrst_n;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       wr;
  logic       rd;
  logic       rxd;
  logic       txd;
  logic       sck;
  logic       sck_oe;
  logic       tx_rdy;
  int         err_total;
  int         checks;

  sfc_top DUT (.CLK_SYS_IN(clk), .NRST_IN(nrst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
               .RDATA_OUT(rdata), .RXD_IN(rxd), .TXD_OUT(txd), .SCK_OUT(sck), .SCK_OE_OUT(sck_oe),
               .TX_READY_OUT(tx_rdy));
  sfc_link_model peer (.clk_in(clk), .txd_in(txd), .sck_in(sck), .rxd_out(rxd));

  // 100 MHz system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_n(input string nm, input int e, input int g);
    checks++;
    if (g != e) begin
      err_total++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // one-cycle strobes, changed just after the rising edge
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // expected async frame, bit 0 first; returns its length in bits
  function automatic int build(input logic [7:0] m, input logic [7:0] d, input logic mpb, output logic [15:0] f);
    int n;
    int nd;
    logic p;
    f = '1;
    f[0] = 1'b0;
    n = 1;
    nd = m[6] ? 7 : 8;
    p = m[4];
    for (int i = 0; i < nd; i++) begin
      f[n] = d[i];
      p ^= d[i];
      n++;
    end
    if (m[2]) begin
      f[n] = mpb;
      n++;
    end else if (m[5]) begin
      f[n] = p;
      n++;
    end
    return n + (m[3] ? 2 : 1);
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic t_reset();
    logic [7:0] d;
    @(negedge clk);
    chk("txd idle", 1, txd);
    chk("sck oe", 0, sck_oe);
    chk("tx ready", 1, tx_rdy);
    rd_reg(`SFC_ADDR_MODE, d);
    chk("mode reset", 8'h00, d);
    rd_reg(3'h7, d);
    chk("unmapped read", 8'h00, d);
    wr_reg(`SFC_ADDR_MODE, 8'h5a);
    wr_reg(3'h7, 8'hff);
    rd_reg(`SFC_ADDR_MODE, d);
    chk("mode rw", 8'h5a, d);
    $display("test reset done");
  endtask

  task automatic t_async();
    logic [7:0]  mt [6] = '{8'h00, 8'h40, 8'h20, 8'h30, 8'h08, 8'h34};
    logic [7:0]  dt [6] = '{8'ha5, 8'h53, 8'h07, 8'h07, 8'h81, 8'h5e};
    logic [15:0] e;
    logic [15:0] f;
    int          n;
    // odd cases set the mp bit so parity and mp bit are told apart
    for (int k = 0; k < 6; k++) begin
      wr_reg(`SFC_ADDR_CTRL, {7'h00, k[0]});
      wr_reg(`SFC_ADDR_MODE, mt[k]);
      n = build(mt[k], dt[k], k[0], e);
      fork
        peer.grab(n, f);
        wr_reg(`SFC_ADDR_HOLD, dt[k]);
      join
      chk("async frame", e, f);
      repeat (3) @(posedge clk);
    end
    $display("test async done");
  endtask

  task automatic t_fill();
    logic [7:0]  w [3] = '{8'h11, 8'h22, 8'h33};
    logic [15:0] e;
    logic [15:0] f [3];
    int          g [3];
    logic [7:0]  d;
    logic        rdy;
    int          n;
    wr_reg(`SFC_ADDR_MODE, 8'h08);
    // shifter plus two buffered words, then a fourth write that must drop
    fork
      for (int i = 0; i < 3; i++) begin
        peer.grab(11, f[i]);
        peer.gap(g[i]);
      end
      begin
        for (int i = 0; i < 3; i++) wr_reg(`SFC_ADDR_HOLD, w[i]);
        @(negedge clk);
        rdy = tx_rdy;
        wr_reg(`SFC_ADDR_HOLD, 8'h44);
        rd_reg(`SFC_ADDR_HOLD, d);
      end
    join
    chk("full ready", 0, rdy);
    chk("holding head", 8'h22, d);
    for (int i = 0; i < 3; i++) begin
      n = build(8'h08, w[i], 1'b0, e);
      chk("two stop frame", e, f[i]);
      chk_n("frame gap", (i < 2) ? 2 : 50, g[i]);
    end
    $display("test fill done");
  endtask

  task automatic t_prescale();
    int pt [4] = '{1, 4, 16, 64};
    int p;
    for (int k = 0; k < 4; k++) begin
      wr_reg(`SFC_ADDR_MODE, {6'h00, k[1:0]});
      fork
        peer.bit_len(p);
        wr_reg(`SFC_ADDR_HOLD, 8'h55);
      join
      chk_n("prescaled bit", pt[k], p);
      repeat (12 * pt[k]) @(posedge clk);
    end
    $display("test prescale done");
  endtask

  task automatic t_sync();
    logic [7:0] d;
    int         r;
    // length, parity and stop bits set on purpose: clocked mode ignores them
    wr_reg(`SFC_ADDR_DIV, 8'h01);
    wr_reg(`SFC_ADDR_MODE, 8'he8);
    @(negedge clk);
    chk("sync clock drive", 1, sck_oe);
    fork
      peer.sync_grab(d, r);
      wr_reg(`SFC_ADDR_HOLD, 8'hb4);
    join
    chk("sync data", 8'hb4, d);
    chk_n("sync bits", 8, r);
    wr_reg(`SFC_ADDR_MODE, 8'h00);
    wr_reg(`SFC_ADDR_DIV, 8'h00);
    $display("test sync done");
  endtask

  task automatic t_card();
    int st [4] = '{32, 64, 372, 256};
    int p;
    wr_reg(`SFC_ADDR_CARD, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr_reg(`SFC_ADDR_MODE, {4'ha, k[1:0], 2'b00});
      @(negedge clk);
      chk("card no sync clock", 0, sck_oe);
      fork
        peer.bit_len(p);
        wr_reg(`SFC_ADDR_HOLD, 8'h55);
      join
      chk_n("card bit", st[k], p);
      repeat (12 * st[k]) @(posedge clk);
    end
    wr_reg(`SFC_ADDR_CARD, 8'h00);
    $display("test card done");
  endtask

  task automatic t_rx();
    logic [7:0] s;
    logic [7:0] d;
    int         c;
    wr_reg(`SFC_ADDR_DIV, 8'h03);
    wr_reg(`SFC_ADDR_MODE, 8'h28);
    // second frame starts where a second stop bit would stand, parity wrong
    fork
      peer.send({9'h000, 3'b111, 8'h3c, 1'b0, 2'b10, 8'h96, 1'b0}, 23, 4);
      begin
        c = 0;
        do begin
          rd_reg(`SFC_ADDR_CTRL, s);
          c++;
        end while (s[3] !== 1'b1 && c < 40);
        rd_reg(`SFC_ADDR_RXDATA, d);
      end
    join
    chk("rx first", 8'h96, d);
    repeat (10) @(posedge clk);
    rd_reg(`SFC_ADDR_CTRL, s);
    chk("rx flags", 8'h18, s & 8'h38);
    rd_reg(`SFC_ADDR_RXDATA, d);
    chk("rx second", 8'h3c, d);
    $display("test receive done");
  endtask

  initial begin
    err_total = 0;
    checks = 0;
    nrst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    repeat (8) @(posedge clk);
    nrst_n <= 1'b1;
    t_reset();
    wr_reg(`SFC_ADDR_DIV, 8'h00);
    wr_reg(`SFC_ADDR_MODE, 8'h00);
    t_async();
    t_fill();
    t_prescale();
    t_sync();
    t_card();
    t_rx();
    results();
  end

  // all tests together take about 12000 clocks
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    $display("CHECK FAILED watchdog expected end seen hang");
    results();
  end
endmodule // tb_top
